//--- shared/sbmcr_map.svh
`ifndef SBMCR_MAP_SVH
`define SBMCR_MAP_SVH

// Register offsets on the command/response register port.
`define SBMCR_OFS_SLAVE_ADDR 8'h11
`define SBMCR_OFS_DIAG_CFG 8'h12
`define SBMCR_OFS_CMD_CFG 8'h13
`define SBMCR_OFS_PERIODIC_CFG 8'h14
`define SBMCR_OFS_PERIODIC_EN 8'h15
`define SBMCR_OFS_PERIOD_SEL 8'h17

// Field positions and masks.
`define SBMCR_ADDR_MASK 8'h0f
`define SBMCR_DIAG_EN_BIT 0
`define SBMCR_SS_EN_BIT 0
`define SBMCR_TRAIN_EN_BIT 1
`define SBMCR_CMD_PER_LSB 2
`define SBMCR_TRAIN_RST_BIT 4
`define SBMCR_CMD_CFG_MASK 8'h1f
`define SBMCR_PER_CFG_MASK 8'h03
`define SBMCR_PER_SEL_MASK 8'h07
`define SBMCR_PER_EN_BIT 7

// Reset values.
`define SBMCR_RST_VAL 8'h00

// Diagnostic fragment length when enabled.
`define SBMCR_DIAG_FRAG_LEN 3'h4

// Periodic periods in microseconds.
`define SBMCR_PER_US_0 16'h01f4
`define SBMCR_PER_US_1 16'h007d
`define SBMCR_PER_US_2 16'h00fa
`define SBMCR_PER_US_3 16'h014d
`define SBMCR_PER_US_4 16'h01f4
`define SBMCR_PER_US_5 16'h03e8
`define SBMCR_PER_US_6 16'h07d0
`define SBMCR_PER_US_7 16'h0fa0

`endif

//--- shared/sbmcr_pkg.sv
`default_nettype none
package sbmcr_pkg;
	typedef enum logic [1:0] {
		SBMCR_OSC_HOLD,
		SBMCR_OSC_UNTRAINED,
		SBMCR_OSC_TRAIN
	} sbmcr_osc_t;
	typedef logic [7:0] sbmcr_byte_t;
endpackage : sbmcr_pkg
`default_nettype wire

//--- logic/sbmcr_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbmcr_map.svh"
module sbmcr_mode_decode (
	// Configuration in.
	input wire logic i_periodic_en,
	input wire logic i_diag_en,
	input wire logic [1:0] i_cmd_per,
	input wire logic [2:0] i_per_sel,
	// Decoded modes.
	output logic o_cmd_resp_active,
	output logic o_periodic_active,
	output logic o_diag_active,
	output logic [2:0] o_diag_frag_len,
	output logic [3:0] o_cmd_per_mult,
	output logic [15:0] o_period_us
);
	import sbmcr_pkg::*;
	assign o_cmd_resp_active = !i_periodic_en;
	assign o_periodic_active = i_periodic_en;
	assign o_diag_active = i_periodic_en & i_diag_en;
	assign o_diag_frag_len = i_diag_en ? `SBMCR_DIAG_FRAG_LEN : 3'h0;
	assign o_cmd_per_mult = 4'h1 << i_cmd_per;
	always_comb begin
		case (i_per_sel)
			3'h0: o_period_us = `SBMCR_PER_US_0;
			3'h1: o_period_us = `SBMCR_PER_US_1;
			3'h2: o_period_us = `SBMCR_PER_US_2;
			3'h3: o_period_us = `SBMCR_PER_US_3;
			3'h4: o_period_us = `SBMCR_PER_US_4;
			3'h5: o_period_us = `SBMCR_PER_US_5;
			3'h6: o_period_us = `SBMCR_PER_US_6;
			3'h7: o_period_us = `SBMCR_PER_US_7;
			default: o_period_us = `SBMCR_PER_US_0;
		endcase
	end
endmodule : sbmcr_mode_decode
`default_nettype wire

//--- logic/sbmcr_regs.sv
// Overview of operation
// - Zero slave address: address comes from discovery or command/response assignment.
// - Nonzero slave address: skip discovery, answer with that address.
// - Master may rewrite the shadow slave address by register write.
// - With user lock set, reset reloads shadow address from programmed value.
// - Shadow address joins read/write verification; programmed value joins OTP verification.
// - Diagnostic enable 0 disables; 1 selects fragment length four.
// - Command period field gives multiple 1, 2, 4 or 8.
// - Command period only affects training; commands answered regardless.
// - Training enable trains oscillator from bus timing; training reset ignored.
// - Enable 0, reset 0: hold last trained oscillator value.
// - Enable 0, reset 1: return oscillator to untrained setting.
// - Sampling select 0: synchronous, latency from response start time.
// - Sampling select 1: simultaneous, latency from command falling edge.
// - Periodic enable set by enter command or register write.
// - Periodic enable locks configuration and starts read/write verification.
// - Once set, periodic enable clears only by device reset.
// - Mode truth table from periodic enable and diagnostic enable.
// - Period select decodes to 500,125,250,333,500,1000,2000,4000 us.
`timescale 1ns/1ps
`default_nettype none
`include "sbmcr_map.svh"
module sbmcr_regs (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Register port from the command decoder.
	input wire logic i_wr_en,
	input wire logic [7:0] i_addr,
	input wire sbmcr_pkg::sbmcr_byte_t i_wdata,
	output sbmcr_pkg::sbmcr_byte_t o_rdata,
	input wire logic i_enter_periodic,
	// Programmed memory values.
	input wire logic [3:0] i_otp_slave_addr,
	input wire logic i_user_lock,
	// Discovery and address status.
	output logic o_discovery_allowed,
	output logic [3:0] o_slave_addr,
	// Oscillator and sampling control.
	output sbmcr_pkg::sbmcr_osc_t o_osc_ctrl,
	output logic o_simultaneous_sampling,
	output logic o_latency_from_cmd_edge,
	output logic [3:0] o_cmd_per_mult,
	output logic [15:0] o_period_us,
	// Mode status.
	output logic o_cmd_resp_active,
	output logic o_periodic_active,
	output logic o_diag_active,
	output logic [2:0] o_diag_frag_len,
	output logic o_cfg_locked,
	output logic o_rw_verify_en,
	output logic [7:0] o_rw_verify_image,
	output logic [3:0] o_otp_verify_image
);
	import sbmcr_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	logic [3:0] slave_addr_ff;
	logic diag_en_ff;
	logic [4:0] cmd_cfg_ff;
	logic [1:0] per_cfg_ff;
	logic [2:0] per_sel_ff;
	logic periodic_en_ff;
	logic otp_load_ff;
	logic nxt_periodic_en;
	logic train_en;
	logic train_rst;
	logic wr_ok;

	// Locked registers take no writes once periodic mode is on.
	assign wr_ok = i_wr_en & !periodic_en_ff;

	// ****************************************
	// Shadow slave address
	// ****************************************
	// The programmed value is caught on the first clock after reset release, never under reset.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			otp_load_ff <= 1'b1;
		end else begin
			otp_load_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			slave_addr_ff <= 4'h0;
		end else if (otp_load_ff) begin
			// Without the lock a reset leaves the address cleared, so discovery runs again.
			if (i_user_lock) begin
				slave_addr_ff <= i_otp_slave_addr;
			end
		end else if (wr_ok && i_addr == `SBMCR_OFS_SLAVE_ADDR) begin
			slave_addr_ff <= i_wdata[3:0];
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			diag_en_ff <= 1'b0;
		end else if (wr_ok && i_addr == `SBMCR_OFS_DIAG_CFG) begin
			diag_en_ff <= i_wdata[`SBMCR_DIAG_EN_BIT];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cmd_cfg_ff <= 5'h00;
		end else if (wr_ok && i_addr == `SBMCR_OFS_CMD_CFG) begin
			cmd_cfg_ff <= i_wdata[4:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			per_cfg_ff <= 2'h0;
		end else if (wr_ok && i_addr == `SBMCR_OFS_PERIODIC_CFG) begin
			per_cfg_ff <= i_wdata[1:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			per_sel_ff <= 3'h0;
		end else if (wr_ok && i_addr == `SBMCR_OFS_PERIOD_SEL) begin
			per_sel_ff <= i_wdata[2:0];
		end
	end

	// ****************************************
	// Periodic mode enable
	// ****************************************
	always_comb begin
		nxt_periodic_en = periodic_en_ff;
		if (i_enter_periodic) begin
			nxt_periodic_en = 1'b1;
		end else if (i_wr_en && i_addr == `SBMCR_OFS_PERIODIC_EN && i_wdata[`SBMCR_PER_EN_BIT]) begin
			nxt_periodic_en = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			periodic_en_ff <= 1'b0;
		end else begin
			periodic_en_ff <= nxt_periodic_en;
		end
	end

	// ****************************************
	// Read back
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_rdata <= `SBMCR_RST_VAL;
		end else begin
			case (i_addr)
				`SBMCR_OFS_SLAVE_ADDR: o_rdata <= {4'h0, slave_addr_ff};
				`SBMCR_OFS_DIAG_CFG: o_rdata <= {7'h00, diag_en_ff};
				`SBMCR_OFS_CMD_CFG: o_rdata <= {3'h0, cmd_cfg_ff};
				`SBMCR_OFS_PERIODIC_CFG: o_rdata <= {6'h00, per_cfg_ff};
				`SBMCR_OFS_PERIODIC_EN: o_rdata <= {periodic_en_ff, 7'h00};
				`SBMCR_OFS_PERIOD_SEL: o_rdata <= {5'h00, per_sel_ff};
				default: o_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Address and oscillator control
	// ****************************************
	// The command decoder uses this to decide whether discovery frames are answered.
	assign o_discovery_allowed = (slave_addr_ff == 4'h0);
	assign o_slave_addr = slave_addr_ff;

	assign train_en = cmd_cfg_ff[`SBMCR_TRAIN_EN_BIT];
	assign train_rst = cmd_cfg_ff[`SBMCR_TRAIN_RST_BIT];
	always_comb begin
		if (train_en) begin
			o_osc_ctrl = SBMCR_OSC_TRAIN;
		end else if (train_rst) begin
			o_osc_ctrl = SBMCR_OSC_UNTRAINED;
		end else begin
			o_osc_ctrl = SBMCR_OSC_HOLD;
		end
	end

	assign o_simultaneous_sampling = cmd_cfg_ff[`SBMCR_SS_EN_BIT];
	assign o_latency_from_cmd_edge = cmd_cfg_ff[`SBMCR_SS_EN_BIT];

	// ****************************************
	// Lock and verification
	// ****************************************
	assign o_cfg_locked = periodic_en_ff;
	assign o_rw_verify_en = periodic_en_ff;
	assign o_rw_verify_image = {4'h0, slave_addr_ff} ^ {diag_en_ff, cmd_cfg_ff, per_cfg_ff};
	assign o_otp_verify_image = i_otp_slave_addr;

	// ****************************************
	// Mode decode
	// ****************************************
	// The command period only shapes training; decoding elsewhere never looks at it.
	sbmcr_mode_decode u_decode (
		.i_periodic_en(periodic_en_ff),
		.i_diag_en(diag_en_ff),
		.i_cmd_per(train_en ? cmd_cfg_ff[3:2] : 2'h0),
		.i_per_sel(per_sel_ff),
		.o_cmd_resp_active(o_cmd_resp_active),
		.o_periodic_active(o_periodic_active),
		.o_diag_active(o_diag_active),
		.o_diag_frag_len(o_diag_frag_len),
		.o_cmd_per_mult(o_cmd_per_mult),
		.o_period_us(o_period_us)
	);
endmodule : sbmcr_regs
`default_nettype wire

//--- testbench/sbmcr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module sbmcr_regs_chk (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Register port and programmed values.
	input wire logic i_wr_en,
	input wire logic [7:0] i_addr,
	input wire sbmcr_pkg::sbmcr_byte_t i_wdata,
	input wire logic i_enter_periodic,
	input wire logic [3:0] i_otp_slave_addr,
	input wire logic i_user_lock,
	// Status.
	input wire logic o_discovery_allowed,
	input wire logic [3:0] o_slave_addr,
	input wire sbmcr_pkg::sbmcr_osc_t o_osc_ctrl,
	input wire logic [3:0] o_cmd_per_mult,
	input wire logic o_cmd_resp_active,
	input wire logic o_periodic_active,
	input wire logic o_diag_active,
	input wire logic o_cfg_locked
);
	import sbmcr_pkg::*;
	// ****
	// Checks.
	// ****
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	a_addr_zero_disc: assert property (o_discovery_allowed == (o_slave_addr == 4'h0))
		else $error("discovery flag disagrees with address");
	a_addr_write: assert property (!$past(i_srst) && i_wr_en && i_addr == 8'h11 && !o_cfg_locked
		|=> o_slave_addr == $past(i_wdata[3:0])) else $error("address write not taken");
	a_lock_reload: assert property ($past(i_srst) && i_user_lock
		|=> o_slave_addr == $past(i_otp_slave_addr)) else $error("address not reloaded");
	a_enter_sets: assert property (i_enter_periodic |=> o_periodic_active)
		else $error("enter command ignored");
	a_en_write: assert property (i_wr_en && i_addr == 8'h15 && i_wdata[7] |=> o_periodic_active)
		else $error("enable write ignored");
	a_periodic_sticky: assert property (o_periodic_active |=> o_periodic_active)
		else $error("periodic enable cleared");
	a_locked_addr: assert property (o_cfg_locked |=> $stable(o_slave_addr))
		else $error("locked address changed");
	a_mode_table: assert property ((o_cmd_resp_active != o_periodic_active) && (!o_diag_active || o_periodic_active))
		else $error("mode table broken");
	a_mult_untrained: assert property (o_osc_ctrl != SBMCR_OSC_TRAIN |-> o_cmd_per_mult == 4'h1)
		else $error("period multiple used without training");
	c_enter: cover property (i_enter_periodic);
	c_reload: cover property ($past(i_srst) && i_user_lock);
	c_train: cover property (o_osc_ctrl == SBMCR_OSC_TRAIN);
endmodule : sbmcr_regs_chk
bind sbmcr_regs sbmcr_regs_chk i_chk (
	.i_ref_clk(i_ref_clk),
	.i_srst(i_srst),
	.i_wr_en(i_wr_en),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_enter_periodic(i_enter_periodic),
	.i_otp_slave_addr(i_otp_slave_addr),
	.i_user_lock(i_user_lock),
	.o_discovery_allowed(o_discovery_allowed),
	.o_slave_addr(o_slave_addr),
	.o_osc_ctrl(o_osc_ctrl),
	.o_cmd_per_mult(o_cmd_per_mult),
	.o_cmd_resp_active(o_cmd_resp_active),
	.o_periodic_active(o_periodic_active),
	.o_diag_active(o_diag_active),
	.o_cfg_locked(o_cfg_locked)
);
`default_nettype wire

//--- testbench/sbmcr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbmcr_master_model (
	// Clock.
	input wire logic i_ref_clk,
	// Requests to the block.
	output logic o_wr_en,
	output logic [7:0] o_addr,
	output sbmcr_pkg::sbmcr_byte_t o_wdata,
	output logic o_enter_periodic
);
	import sbmcr_pkg::*;
	// ****
	// Requests.
	// ****
	initial begin
		o_wr_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_enter_periodic = 1'b0;
	end
	// Released data is inverted so a stale byte can never pass for a fresh one.
	task automatic wr(input logic [7:0] a, input sbmcr_byte_t d);
		@(negedge i_ref_clk);
		o_addr = a;
		o_wdata = d;
		o_wr_en = 1'b1;
		@(negedge i_ref_clk);
		o_wr_en = 1'b0;
		o_wdata = ~d;
	endtask : wr
	task automatic enter();
		@(negedge i_ref_clk);
		o_enter_periodic = 1'b1;
		@(negedge i_ref_clk);
		o_enter_periodic = 1'b0;
	endtask : enter
	task automatic rd(input logic [7:0] a);
		@(negedge i_ref_clk);
		o_addr = a;
		@(negedge i_ref_clk);
	endtask : rd
endmodule : sbmcr_master_model
`default_nettype wire

//--- testbench/test_sensor_bus_mode_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_sensor_bus_mode_config_regs;
	import sbmcr_pkg::*;
	logic i_ref_clk, i_srst, i_wr_en, i_enter_periodic, i_user_lock, o_discovery_allowed, o_simultaneous_sampling;
	logic o_latency_from_cmd_edge, o_cmd_resp_active, o_periodic_active, o_diag_active, o_cfg_locked, o_rw_verify_en;
	logic [7:0] i_addr, o_rw_verify_image;
	logic [3:0] i_otp_slave_addr, o_slave_addr, o_cmd_per_mult, o_otp_verify_image;
	logic [2:0] o_diag_frag_len;
	logic [15:0] o_period_us;
	sbmcr_byte_t i_wdata, o_rdata;
	sbmcr_osc_t o_osc_ctrl;
	int n_mismatch = 0;
	int num_checks = 0;
	// ****
	// Harness.
	// ****
	sbmcr_regs i_dut (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_wr_en(i_wr_en),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.o_rdata(o_rdata),
		.i_enter_periodic(i_enter_periodic),
		.i_otp_slave_addr(i_otp_slave_addr),
		.i_user_lock(i_user_lock),
		.o_discovery_allowed(o_discovery_allowed),
		.o_slave_addr(o_slave_addr),
		.o_osc_ctrl(o_osc_ctrl),
		.o_simultaneous_sampling(o_simultaneous_sampling),
		.o_latency_from_cmd_edge(o_latency_from_cmd_edge),
		.o_cmd_per_mult(o_cmd_per_mult),
		.o_period_us(o_period_us),
		.o_cmd_resp_active(o_cmd_resp_active),
		.o_periodic_active(o_periodic_active),
		.o_diag_active(o_diag_active),
		.o_diag_frag_len(o_diag_frag_len),
		.o_cfg_locked(o_cfg_locked),
		.o_rw_verify_en(o_rw_verify_en),
		.o_rw_verify_image(o_rw_verify_image),
		.o_otp_verify_image(o_otp_verify_image)
	);
	sbmcr_master_model i_mst (.i_ref_clk(i_ref_clk), .o_wr_en(i_wr_en), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_enter_periodic(i_enter_periodic));
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rst();
		@(negedge i_ref_clk);
		i_srst = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		i_srst = 1'b0;
		@(negedge i_ref_clk);
	endtask : rst
	// ****
	// Scenarios.
	// ****
	task automatic t_regs();
		logic [7:0] ofs[7] = '{8'h11, 8'h12, 8'h13, 8'h15, 8'h20, 8'h14, 8'h17};
		logic [7:0] msk[7] = '{8'h0f, 8'h01, 8'h1f, 8'h80, 8'h00, 8'h03, 8'h07};
		for (int k = 0; k < 7; k++) begin
			i_mst.rd(ofs[k]);
			chk("reset value", 16'h0000, o_rdata);
		end
		for (int k = 0; k < 7; k++) begin
			if (k != 3) begin
				i_mst.wr(ofs[k], 8'hff);
				i_mst.rd(ofs[k]);
				chk("readback", msk[k], o_rdata);
			end
		end
	endtask : t_regs
	task automatic t_osc();
		for (int p = 0; p < 4; p++) begin
			i_mst.wr(8'h13, {3'h0, 1'b1, p[1:0], 1'b1, 1'b0});
			chk("osc", SBMCR_OSC_TRAIN, o_osc_ctrl);
			chk("mult", 16'h0001 << p, o_cmd_per_mult);
		end
		i_mst.wr(8'h13, 8'h1c);
		chk("osc", SBMCR_OSC_UNTRAINED, o_osc_ctrl);
		chk("mult", 16'h0001, o_cmd_per_mult);
		i_mst.wr(8'h13, 8'h01);
		chk("osc", SBMCR_OSC_HOLD, o_osc_ctrl);
		chk("sampling", 16'h0001, o_simultaneous_sampling);
		i_mst.wr(8'h13, 8'h00);
		chk("sampling", 16'h0000, o_latency_from_cmd_edge);
	endtask : t_osc
	task automatic t_period();
		logic [15:0] us[8] = '{16'h01f4, 16'h007d, 16'h00fa, 16'h014d, 16'h01f4, 16'h03e8, 16'h07d0, 16'h0fa0};
		for (int k = 0; k < 8; k++) begin
			i_mst.wr(8'h17, k[7:0]);
			chk("period", us[k], o_period_us);
		end
	endtask : t_period
	task automatic t_addr();
		i_mst.wr(8'h11, 8'h00);
		chk("discovery", 16'h0001, o_discovery_allowed);
		i_mst.wr(8'h11, 8'hf6);
		chk("address", 16'h0006, o_slave_addr);
		chk("discovery", 16'h0000, o_discovery_allowed);
		i_user_lock = 1'b1;
		i_otp_slave_addr = 4'h9;
		rst();
		chk("address", 16'h0009, o_slave_addr);
		chk("otp image", 16'h0009, o_otp_verify_image);
		chk("rw image", 16'h0009, o_rw_verify_image);
		i_mst.wr(8'h11, 8'h03);
		rst();
		chk("address", 16'h0009, o_slave_addr);
		i_user_lock = 1'b0;
		rst();
	endtask : t_addr
	task automatic t_periodic();
		i_mst.wr(8'h12, 8'h01);
		chk("frag", 16'h0004, o_diag_frag_len);
		chk("diag", 16'h0000, o_diag_active);
		i_mst.enter();
		chk("periodic", 16'h0001, o_periodic_active);
		chk("cmd resp", 16'h0000, o_cmd_resp_active);
		chk("diag", 16'h0001, o_diag_active);
		chk("verify", 16'h0001, o_rw_verify_en);
		i_mst.wr(8'h11, 8'h05);
		chk("address", 16'h0000, o_slave_addr);
		i_mst.wr(8'h15, 8'h00);
		chk("periodic", 16'h0001, o_periodic_active);
		rst();
		chk("periodic", 16'h0000, o_cfg_locked);
		i_mst.wr(8'h15, 8'h80);
		chk("periodic", 16'h0001, o_periodic_active);
		chk("diag", 16'h0000, o_diag_active);
		chk("frag", 16'h0000, o_diag_frag_len);
	endtask : t_periodic
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		i_srst = 1'b1;
		i_user_lock = 1'b0;
		i_otp_slave_addr = 4'h0;
		rst();
		t_regs();
		t_osc();
		t_period();
		t_addr();
		t_periodic();
		tally_and_finish();
	end
endmodule : test_sensor_bus_mode_config_regs
`default_nettype wire
